// File: hdl/csc_pkg.sv
/*
 * Shared constants for the channel buffer steering control block.
 * Assumes one 100 MHz clock and a synchronous active-low reset.
 */
package csc_pkg;

    localparam int CSC_CLOCK_MHZ = 100;
    localparam int CSC_SYNC_STAGES = 3;

    // Positions in the control vector
    localparam int CSC_NUM_CTL = 9;
    localparam int CSC_BIT_RD_EN = 0;
    localparam int CSC_BIT_RD_LATCH0 = 1;
    localparam int CSC_BIT_WR_EN0 = 2;
    localparam int CSC_BIT_WR_EN1 = 3;
    localparam int CSC_BIT_WR_ENH = 4;
    localparam int CSC_BIT_WR_LATCH = 5;
    localparam int CSC_BIT_BYTE_SWAP = 6;
    localparam int CSC_BIT_WORD_SWAP = 7;
    localparam int CSC_BIT_SWAP_DIR = 8;

    // Pin levels after reset: enables, swaps, direction high; latches low
    localparam logic [CSC_NUM_CTL-1:0] CSC_CTL_RESET = 9'h1DD;

    localparam logic CSC_DIR_LOW_TO_HIGH = 1'b0;
    localparam logic CSC_DIR_HIGH_TO_LOW = 1'b1;
    localparam logic CSC_STRAP_RESET = 1'b1;
    localparam logic CSC_DRIVE_RESET = 1'b1;
    localparam logic [7:0] CSC_DATA_RESET = 8'h00;

    typedef enum logic [2:0]
    {
        CSC_KIND_CPU_RD_CH = 3'h0,
        CSC_KIND_CPU_WR_CH = 3'h1,
        CSC_KIND_MST_WR_MEM = 3'h2,
        CSC_KIND_MST_RD_MEM = 3'h3,
        CSC_KIND_REG_RD = 3'h4,
        CSC_KIND_REG_WR = 3'h5
    } csc_kind_type;

    typedef enum logic [3:0]
    {
        CSC_ST_IDLE = 4'h1,
        CSC_ST_FULL = 4'h2,
        CSC_ST_HALF_LO = 4'h4,
        CSC_ST_HALF_HI = 4'h8
    } csc_state_type;

endpackage

// File: hdl/csc_pin_if.sv
/*
 * Carrier between the steering core and its pin stage.
 * Assumes both ends run on the same clock.
 */
interface csc_pin_if;
    import csc_pkg::*;

    logic [CSC_NUM_CTL-1:0] ctl_next;
    logic [CSC_NUM_CTL-1:0] ctl;
    logic drive_en;

    modport core
    (
        output ctl_next,
        input ctl,
        input drive_en
    );

    modport stage
    (
        input ctl_next,
        output ctl,
        output drive_en
    );
endinterface

// File: hdl/csc_pin_stage.sv
/*
 * Output register for the buffer controls and board-test pin handling.
 * Assumes the test pin is asynchronous to the clock.
 */
module csc_pin_stage
    import csc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic TEST_N,
    csc_pin_if.stage pins
);

    logic [CSC_SYNC_STAGES-1:0] test_sync_reg;
    logic [CSC_NUM_CTL-1:0] ctl_reg;
    logic drive_en_reg;
    wire test_settled = (test_sync_reg[1] == test_sync_reg[2]);

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            test_sync_reg <= '1;
            ctl_reg <= CSC_CTL_RESET;
            drive_en_reg <= CSC_DRIVE_RESET;
        end
        else
        begin
            test_sync_reg <= {test_sync_reg[1:0], TEST_N};
            ctl_reg <= pins.ctl_next;
            if (test_settled)
            begin
                drive_en_reg <= test_sync_reg[2];
            end
        end
    end

    assign pins.ctl = ctl_reg;
    assign pins.drive_en = drive_en_reg;

endmodule

// File: hdl/csc_steering.sv
/*
 * Channel buffer steering control: enables, latches and swap controls
 * for the external data buffers between the local bus and the Channel.
 * Assumes a cycle sequencer on the same clock that issues requests and
 * marks the end of each Channel cycle.
 */
// Operation
// - Read enable on local reads from Channel
// - Read enable for master writes, register writes
// - 8-bit reads split, byte 0 latched first
// - Three write enables: byte0, byte1, upper
// - Write enables on local writes, master reads
// - Write enables on register reads too
// - Write latch holds local write data
// - 8-bit writes split, latch holds data
// - Byte swap for 8-bit port accesses
// - Word swap for 16-bit master, 32-bit slave
// - Swap direction strap sampled after reset
// - Swap direction driven as output afterwards
// - Test low tristates all outputs; reset still forces CTL_OE high whatever TEST_N is
// - Test high drives outputs normally
// - Defined pin levels after reset
module csc_steering
    import csc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic TEST_N,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_KIND,
    input wire logic REQ_PORT8,
    input wire logic REQ_MASTER16,
    input wire logic [7:0] REQ_RDATA,
    output logic REQ_READY,
    output logic REQ_DROPPED,
    input wire logic CH_CYCLE_END,
    output logic ACC_DONE,
    output logic [7:0] REG_WDATA,
    output logic CTL_OE,
    output logic READ_BUFFER_ENABLE_N,
    output logic BYTE0_READ_LATCH_ENABLE,
    output logic WRITE_BUFFER_ENABLE_BYTE0_N,
    output logic WRITE_BUFFER_ENABLE_BYTE1_N,
    output logic WRITE_BUFFER_ENABLE_UPPER_WORD_N,
    output logic WRITE_LATCH_ENABLE,
    output logic BYTE_SWAP_CONTROL_N,
    output logic WORD_SWAP_CONTROL_N,
    input wire logic SWAP_DIRECTION_IN,
    output logic SWAP_DIRECTION_OUT,
    output logic SWAP_DIRECTION_OE,
    output logic COPROCESSOR_ABSENT_STRAP,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE
);

    csc_pin_if pin_bus ();

    csc_pin_stage u_pin_stage
    (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .TEST_N(TEST_N),
        .pins(pin_bus.stage)
    );

    csc_state_type state_reg;
    csc_state_type state_next;
    csc_kind_type kind_reg;
    csc_kind_type kind_next;
    logic master16_reg;
    logic master16_next;
    logic done_reg;
    logic dropped_reg;
    logic [7:0] data_out_reg;
    logic data_oe_reg;
    logic [7:0] reg_wdata_reg;

    // Strap input passes three flops before use
    logic [CSC_SYNC_STAGES-1:0] dir_sync_reg;
    logic strap_reg;
    logic strap_done_reg;

    wire dir_settled = (dir_sync_reg[1] == dir_sync_reg[2]);
    wire idle = (state_reg == CSC_ST_IDLE);
    // No access is taken until the strap has been caught
    wire ready = idle && strap_done_reg;
    wire accept = ready && REQ_VALID;
    wire req_cpu_channel = (csc_kind_type'(REQ_KIND) == CSC_KIND_CPU_RD_CH)
                        || (csc_kind_type'(REQ_KIND) == CSC_KIND_CPU_WR_CH);
    wire req_split = REQ_PORT8 && req_cpu_channel;
    wire end_full = (state_reg == CSC_ST_FULL) && CH_CYCLE_END;
    wire end_lo = (state_reg == CSC_ST_HALF_LO) && CH_CYCLE_END;
    wire end_hi = (state_reg == CSC_ST_HALF_HI) && CH_CYCLE_END;
    wire finishing = end_full || end_hi;

    assign kind_next = accept ? csc_kind_type'(REQ_KIND) : kind_reg;
    assign master16_next = accept ? REQ_MASTER16 : master16_reg;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            CSC_ST_IDLE:
            begin
                if (accept)
                begin
                    state_next = req_split ? CSC_ST_HALF_LO : CSC_ST_FULL;
                end
            end
            CSC_ST_FULL:
            begin
                if (end_full)
                begin
                    state_next = CSC_ST_IDLE;
                end
            end
            CSC_ST_HALF_LO:
            begin
                if (end_lo)
                begin
                    state_next = CSC_ST_HALF_HI;
                end
            end
            CSC_ST_HALF_HI:
            begin
                if (end_hi)
                begin
                    state_next = CSC_ST_IDLE;
                end
            end
            default:
            begin
                state_next = CSC_ST_IDLE;
            end
        endcase
    end

    // Controls are decoded from the coming state so that the pin
    // register lines them up with the state itself.
    wire busy_n = (state_next != CSC_ST_IDLE);
    wire first_n = (state_next == CSC_ST_HALF_LO);
    wire second_n = (state_next == CSC_ST_HALF_HI);
    wire k_cpu_rd = (kind_next == CSC_KIND_CPU_RD_CH);
    wire k_cpu_wr = (kind_next == CSC_KIND_CPU_WR_CH);
    wire k_mst_wr = (kind_next == CSC_KIND_MST_WR_MEM);
    wire k_mst_rd = (kind_next == CSC_KIND_MST_RD_MEM);
    wire k_reg_rd = (kind_next == CSC_KIND_REG_RD);
    wire k_reg_wr = (kind_next == CSC_KIND_REG_WR);

    wire rd_flow = busy_n && (k_cpu_rd || k_mst_wr || k_reg_wr);
    wire wr_flow = busy_n && (k_cpu_wr || k_mst_rd || k_reg_rd);
    wire rd_allowed = rd_flow && !wr_flow;

    wire latch0_on = rd_allowed && k_cpu_rd && first_n;
    wire byte_swap_on = second_n;
    // byte 0 buffer off while swap drives low byte
    wire wr0_on = wr_flow && !(second_n && k_cpu_wr);
    wire wr_latch_on = wr_flow && k_cpu_wr;
    wire word_swap_on = busy_n && master16_next && (k_mst_wr || k_mst_rd);
    wire low_to_high = k_cpu_rd || k_mst_wr;
    wire steer_on = byte_swap_on || word_swap_on;
    wire dir_level = (steer_on && low_to_high) ? CSC_DIR_LOW_TO_HIGH : CSC_DIR_HIGH_TO_LOW;

    always_comb
    begin
        pin_bus.ctl_next = CSC_CTL_RESET;
        pin_bus.ctl_next[CSC_BIT_RD_EN] = !rd_allowed;
        pin_bus.ctl_next[CSC_BIT_RD_LATCH0] = latch0_on;
        pin_bus.ctl_next[CSC_BIT_WR_EN0] = !wr0_on;
        pin_bus.ctl_next[CSC_BIT_WR_EN1] = !wr_flow;
        pin_bus.ctl_next[CSC_BIT_WR_ENH] = !wr_flow;
        pin_bus.ctl_next[CSC_BIT_WR_LATCH] = wr_latch_on;
        pin_bus.ctl_next[CSC_BIT_BYTE_SWAP] = !byte_swap_on;
        pin_bus.ctl_next[CSC_BIT_WORD_SWAP] = !word_swap_on;
        pin_bus.ctl_next[CSC_BIT_SWAP_DIR] = dir_level;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            state_reg <= CSC_ST_IDLE;
            kind_reg <= CSC_KIND_CPU_RD_CH;
            master16_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            master16_reg <= master16_next;
        end
    end

    // ACC_DONE pulses one cycle; REQ_DROPPED stays high for each cycle that a request is refused
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            done_reg <= 1'b0;
            dropped_reg <= 1'b0;
        end
        else
        begin
            done_reg <= finishing;
            // Requests while busy are ignored, not queued
            dropped_reg <= REQ_VALID && !ready;
        end
    end

    // chain keeps shifting in reset, so the
    // pin level is already settled when reset lifts
    always_ff @(posedge CLOCK)
    begin
        dir_sync_reg <= {dir_sync_reg[1:0], SWAP_DIRECTION_IN};
    end

    // strap caught at the first edge after release
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            strap_reg <= CSC_STRAP_RESET;
            strap_done_reg <= 1'b0;
        end
        else
        begin
            if (!strap_done_reg && dir_settled)
            begin
                strap_reg <= dir_sync_reg[2];
                strap_done_reg <= 1'b1;
            end
        end
    end

    // Register data path on the low byte
    wire capture_rdata = accept && (csc_kind_type'(REQ_KIND) == CSC_KIND_REG_RD);
    wire capture_wdata = end_full && (kind_reg == CSC_KIND_REG_WR);

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            data_out_reg <= CSC_DATA_RESET;
        end
        else if (capture_rdata)
        begin
            data_out_reg <= REQ_RDATA;
        end
    end

    // data pins float outside register reads
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            data_oe_reg <= 1'b0;
        end
        else
        begin
            data_oe_reg <= busy_n && k_reg_rd;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            reg_wdata_reg <= CSC_DATA_RESET;
        end
        else if (capture_wdata)
        begin
            reg_wdata_reg <= DATA_IN;
        end
    end

    assign REQ_READY = ready;
    assign REQ_DROPPED = dropped_reg;
    assign ACC_DONE = done_reg;
    assign REG_WDATA = reg_wdata_reg;
    assign COPROCESSOR_ABSENT_STRAP = strap_reg;

    // one enable for all control pins except swap direction, which has SWAP_DIRECTION_OE
    assign CTL_OE = pin_bus.drive_en;
    assign READ_BUFFER_ENABLE_N = pin_bus.ctl[CSC_BIT_RD_EN];
    assign BYTE0_READ_LATCH_ENABLE = pin_bus.ctl[CSC_BIT_RD_LATCH0];
    assign WRITE_BUFFER_ENABLE_BYTE0_N = pin_bus.ctl[CSC_BIT_WR_EN0];
    assign WRITE_BUFFER_ENABLE_BYTE1_N = pin_bus.ctl[CSC_BIT_WR_EN1];
    assign WRITE_BUFFER_ENABLE_UPPER_WORD_N = pin_bus.ctl[CSC_BIT_WR_ENH];
    assign WRITE_LATCH_ENABLE = pin_bus.ctl[CSC_BIT_WR_LATCH];
    assign BYTE_SWAP_CONTROL_N = pin_bus.ctl[CSC_BIT_BYTE_SWAP];
    assign WORD_SWAP_CONTROL_N = pin_bus.ctl[CSC_BIT_WORD_SWAP];
    assign SWAP_DIRECTION_OUT = pin_bus.ctl[CSC_BIT_SWAP_DIR];
    // pin stays an input until the strap is held
    assign SWAP_DIRECTION_OE = pin_bus.drive_en && strap_done_reg;
    // data low byte floats unless a register read
    assign DATA_OUT = data_out_reg;
    assign DATA_OE = data_oe_reg && pin_bus.drive_en;

endmodule

// File: tb/csc_steering_props.sv
/*
 * Pin-level assertions for the channel buffer steering control.
 * Assumes one clock and the synchronous active-low reset of the block.
 */
module csc_steering_props
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic TEST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic REQ_DROPPED,
    input wire logic CH_CYCLE_END,
    input wire logic ACC_DONE,
    input wire logic CTL_OE,
    input wire logic READ_BUFFER_ENABLE_N,
    input wire logic BYTE0_READ_LATCH_ENABLE,
    input wire logic WRITE_BUFFER_ENABLE_BYTE0_N,
    input wire logic WRITE_BUFFER_ENABLE_BYTE1_N,
    input wire logic WRITE_BUFFER_ENABLE_UPPER_WORD_N,
    input wire logic WRITE_LATCH_ENABLE,
    input wire logic BYTE_SWAP_CONTROL_N,
    input wire logic WORD_SWAP_CONTROL_N,
    input wire logic SWAP_DIRECTION_OUT,
    input wire logic SWAP_DIRECTION_OE,
    input wire logic DATA_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    chk_no_overlap: assert property (
        !READ_BUFFER_ENABLE_N |-> WRITE_BUFFER_ENABLE_BYTE0_N && WRITE_BUFFER_ENABLE_BYTE1_N
        && WRITE_BUFFER_ENABLE_UPPER_WORD_N) else $error("read and write enables overlap");
    // Reset itself is the cause here, so no disable
    chk_reset_levels: assert property (disable iff (1'b0) !NRST |=> READ_BUFFER_ENABLE_N
        && !BYTE0_READ_LATCH_ENABLE && WRITE_BUFFER_ENABLE_BYTE0_N && WRITE_BUFFER_ENABLE_BYTE1_N
        && WRITE_BUFFER_ENABLE_UPPER_WORD_N && !WRITE_LATCH_ENABLE && BYTE_SWAP_CONTROL_N
        && WORD_SWAP_CONTROL_N && SWAP_DIRECTION_OUT && CTL_OE && !DATA_OE && !SWAP_DIRECTION_OE)
        else $error("pin levels wrong after reset");
    chk_test_float: assert property (!TEST_N [*6] |-> !CTL_OE && !SWAP_DIRECTION_OE)
        else $error("outputs still driven in board test");
    chk_test_drive: assert property (TEST_N [*6] |-> CTL_OE)
        else $error("outputs not driven outside board test");
    chk_split_read: assert property (
        BYTE0_READ_LATCH_ENABLE && CH_CYCLE_END |=> !BYTE0_READ_LATCH_ENABLE
        && !BYTE_SWAP_CONTROL_N && !READ_BUFFER_ENABLE_N) else $error("split read second half wrong");
    chk_write_latch: assert property (
        WRITE_LATCH_ENABLE |-> READ_BUFFER_ENABLE_N && !WRITE_BUFFER_ENABLE_BYTE1_N)
        else $error("write latch outside a write");
    chk_swap_dir: assert property (
        !BYTE_SWAP_CONTROL_N || !WORD_SWAP_CONTROL_N |-> SWAP_DIRECTION_OUT == READ_BUFFER_ENABLE_N)
        else $error("swap direction wrong");
    chk_drop_pulse: assert property (REQ_VALID && !REQ_READY |=> REQ_DROPPED)
        else $error("refused request not flagged");
    chk_done_idle: assert property (ACC_DONE |-> $past(CH_CYCLE_END) && READ_BUFFER_ENABLE_N
        && WRITE_BUFFER_ENABLE_BYTE0_N && BYTE_SWAP_CONTROL_N && WORD_SWAP_CONTROL_N)
        else $error("done without idle controls");
endmodule

bind csc_steering csc_steering_props u_chk (.CLOCK, .NRST, .TEST_N, .REQ_VALID, .REQ_READY,
    .REQ_DROPPED, .CH_CYCLE_END, .ACC_DONE, .CTL_OE, .READ_BUFFER_ENABLE_N, .BYTE0_READ_LATCH_ENABLE,
    .WRITE_BUFFER_ENABLE_BYTE0_N, .WRITE_BUFFER_ENABLE_BYTE1_N, .WRITE_BUFFER_ENABLE_UPPER_WORD_N,
    .WRITE_LATCH_ENABLE, .BYTE_SWAP_CONTROL_N, .WORD_SWAP_CONTROL_N, .SWAP_DIRECTION_OUT,
    .SWAP_DIRECTION_OE, .DATA_OE);

// File: tb/csc_xcvr_model.sv
/*
 * Far side: strap resistor on the swap direction pin and the data transceiver.
 * Assumes the block's output enables are high while it drives.
 */
module csc_xcvr_model
(
    input wire logic strap_level,
    input wire logic [7:0] bus_data,
    input wire logic swap_out,
    input wire logic swap_oe,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic swap_in,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign swap_in = swap_oe ? swap_out : strap_level;
    assign data_in = data_oe ? data_out : bus_data;
endmodule

// File: tb/channel_buffer_steering_control_tb_top.sv
/*
 * Self-checking bench for the steering block: requests, channel cycle ends, test pin.
 * Assumes the transceiver model on the strap and data pins.
 */
module channel_buffer_steering_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 0, NRST = 0, TEST_N = 1, REQ_VALID = 0, REQ_PORT8 = 0, REQ_MASTER16 = 0;
    logic CH_CYCLE_END = 0, strap = 1;
    logic [2:0] REQ_KIND = 3'h0;
    logic [7:0] REQ_RDATA = 8'hA5, bus_data = 8'h3C;
    logic REQ_READY, REQ_DROPPED, ACC_DONE, CTL_OE, DATA_OE, COPROCESSOR_ABSENT_STRAP;
    logic READ_BUFFER_ENABLE_N, BYTE0_READ_LATCH_ENABLE, WRITE_BUFFER_ENABLE_BYTE0_N;
    logic WRITE_BUFFER_ENABLE_BYTE1_N, WRITE_BUFFER_ENABLE_UPPER_WORD_N, WRITE_LATCH_ENABLE;
    logic BYTE_SWAP_CONTROL_N, WORD_SWAP_CONTROL_N, SWAP_DIRECTION_IN, SWAP_DIRECTION_OUT, SWAP_DIRECTION_OE;
    logic [7:0] REG_WDATA, DATA_IN, DATA_OUT;
    logic [8:0] ctl;
    int num_errors = 0, num_checks = 0;

    assign ctl = {SWAP_DIRECTION_OUT, WORD_SWAP_CONTROL_N, BYTE_SWAP_CONTROL_N, WRITE_LATCH_ENABLE,
        WRITE_BUFFER_ENABLE_UPPER_WORD_N, WRITE_BUFFER_ENABLE_BYTE1_N, WRITE_BUFFER_ENABLE_BYTE0_N,
        BYTE0_READ_LATCH_ENABLE, READ_BUFFER_ENABLE_N};

    csc_steering dut (.CLOCK, .NRST, .TEST_N, .REQ_VALID, .REQ_KIND, .REQ_PORT8, .REQ_MASTER16, .REQ_RDATA,
        .REQ_READY, .REQ_DROPPED, .CH_CYCLE_END, .ACC_DONE, .REG_WDATA, .CTL_OE, .READ_BUFFER_ENABLE_N,
        .BYTE0_READ_LATCH_ENABLE, .WRITE_BUFFER_ENABLE_BYTE0_N, .WRITE_BUFFER_ENABLE_BYTE1_N,
        .WRITE_BUFFER_ENABLE_UPPER_WORD_N, .WRITE_LATCH_ENABLE, .BYTE_SWAP_CONTROL_N, .WORD_SWAP_CONTROL_N,
        .SWAP_DIRECTION_IN, .SWAP_DIRECTION_OUT, .SWAP_DIRECTION_OE, .COPROCESSOR_ABSENT_STRAP, .DATA_IN,
        .DATA_OUT, .DATA_OE);
    csc_xcvr_model xcvr (.strap_level(strap), .bus_data(bus_data), .swap_out(SWAP_DIRECTION_OUT),
        .swap_oe(SWAP_DIRECTION_OE), .data_out(DATA_OUT), .data_oe(DATA_OE), .swap_in(SWAP_DIRECTION_IN),
        .data_in(DATA_IN));

    initial
    begin
        forever #5 CLOCK = ~CLOCK;
    end

    task automatic print_verdict;
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        for (int n = 0; n < 20 && REQ_READY !== 1'b1; n++)
            @(negedge CLOCK);
    endtask

    task automatic acc(input logic [2:0] k, input logic p8, input logic m16);
        wait_ready();
        REQ_KIND = k;
        REQ_PORT8 = p8;
        REQ_MASTER16 = m16;
        REQ_VALID = 1;
        @(negedge CLOCK);
        REQ_VALID = 0;
    endtask

    // Waits one cycle first, so a Channel cycle lasts two clocks
    task automatic fin_cycle;
        @(negedge CLOCK);
        CH_CYCLE_END = 1;
        @(negedge CLOCK);
        CH_CYCLE_END = 0;
    endtask

    task automatic end_access;
        fin_cycle();
        chk(ctl, 9'h1DD);
        chk({8'h00, ACC_DONE}, 9'h001);
    endtask

    task automatic t_strap(input logic lvl);
        strap = lvl;
        NRST = 0;
        repeat (4) @(negedge CLOCK);
        chk(ctl, 9'h1DD);
        chk({6'h00, DATA_OE, SWAP_DIRECTION_OE, REQ_READY}, 9'h000);
        NRST = 1;
        wait_ready();
        chk({7'h00, COPROCESSOR_ABSENT_STRAP, SWAP_DIRECTION_OE}, {7'h00, lvl, 1'b1});
    endtask

    task automatic t_kinds;
        logic [8:0] exp [6] = '{9'h1DC, 9'h1E1, 9'h1DC, 9'h1C1, 9'h1C1, 9'h1DC};
        for (int k = 0; k < 6; k++)
        begin
            acc(k[2:0], 1'b0, 1'b0);
            chk(ctl, exp[k]);
            if (k == 4)
                chk({DATA_OE, DATA_OUT}, {1'b1, REQ_RDATA});
            end_access();
            if (k == 5)
                chk({1'b0, REG_WDATA}, {1'b0, bus_data});
        end
    endtask

    task automatic t_split;
        acc(3'h0, 1'b1, 1'b0);
        chk(ctl, 9'h1DE);
        fin_cycle();
        chk(ctl, 9'h09C);
        end_access();
        acc(3'h1, 1'b1, 1'b0);
        chk(ctl, 9'h1E1);
        fin_cycle();
        chk(ctl, 9'h1A5);
        end_access();
    endtask

    task automatic t_master;
        acc(3'h2, 1'b0, 1'b1);
        chk(ctl, 9'h05C);
        end_access();
        acc(3'h3, 1'b0, 1'b1);
        chk(ctl, 9'h141);
        end_access();
    endtask

    task automatic t_drop;
        acc(3'h0, 1'b0, 1'b0);
        @(negedge CLOCK);
        REQ_VALID = 1;
        @(negedge CLOCK);
        REQ_VALID = 0;
        chk({8'h00, REQ_DROPPED}, 9'h001);
        end_access();
    endtask

    task automatic t_test;
        TEST_N = 0;
        repeat (7) @(negedge CLOCK);
        chk({7'h00, CTL_OE, SWAP_DIRECTION_OE}, 9'h000);
        TEST_N = 1;
        repeat (7) @(negedge CLOCK);
        chk({7'h00, CTL_OE, SWAP_DIRECTION_OE}, 9'h003);
    endtask

    initial
    begin
        #20000;
        num_errors++;
        print_verdict();
    end

    initial
    begin
        @(negedge CLOCK);
        t_strap(1'b1);
        t_kinds();
        t_split();
        t_master();
        t_drop();
        t_test();
        t_strap(1'b0);
        print_verdict();
    end
endmodule
